// ---- logic/ref_ladder_pkg.sv ----
// Package with register map, field positions and reset values of the reference ladder control.
package ref_ladder_pkg;
    localparam int          ADDR_W              = 4;
    localparam logic [3:0]  ADDR_CONTROL_A      = 4'h0;
    localparam logic [3:0]  ADDR_LEVEL          = 4'h4;
    localparam logic [3:0]  ADDR_FIXED_REF      = 4'h8;
    localparam logic [3:0]  ADDR_PIN_STATUS     = 4'hc;
    localparam int          BIT_CONV_EN         = 7;
    localparam int          BIT_RANGE_SEL       = 6;
    localparam int          BIT_PIN_OE          = 5;
    localparam int          BIT_POS_SRC         = 2;
    localparam int          BIT_BUF_EN          = 5;
    localparam int          BIT_BUF_SRC         = 4;
    localparam int          BIT_FIXED_EN        = 7;
    localparam int          LEVEL_W             = 5;
    localparam logic [7:0]  CTRL_A_MASK         = 8'he4;
    localparam logic [7:0]  FIXED_MASK          = 8'hb0;
    localparam logic [7:0]  RESET_VALUE         = 8'h00;
    localparam logic [3:0]  EXP_LIMITED         = 4'h9;
    localparam logic [3:0]  EXP_FULL            = 4'h5;
    localparam logic [31:0] READ_ZERO           = 32'h0000_0000;
endpackage

// ---- logic/ref_pin_mux.sv ----
// Pin routing for the shared reference output pin and its digital override.
`timescale 1ns/10ps
module ref_pin_mux (
    input  wire logic sys_clk_i,
    input  wire logic arst_n_i,
    input  wire logic pin_output_enable_i,
    input  wire logic buffer_enable_i,
    input  wire logic buffer_source_select_i,
    input  wire logic port_out_i,
    input  wire logic port_oe_i,
    input  wire logic pin_in_i,
    output logic      unbuffered_ref_o,
    output logic      buffered_ref_o,
    output logic      buffer_feed_ladder_o,
    output logic      pin_dig_out_o,
    output logic      pin_dig_oe_o,
    output logic      pin_read_o
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic unbuf;
        logic buf_on;
        logic feed;
        logic dout;
        logic doe;
        logic rd;
    } mux_s;

    mux_s state_reg;
    mux_s state_next;
    logic ref_active;

    always_comb begin
        state_next = state_reg;
        // Pin input passes three flops; a change counts once the last two agree.
        state_next.s1 = pin_in_i;
        state_next.s2 = state_reg.s1;
        state_next.s3 = state_reg.s2;
        state_next.unbuf = pin_output_enable_i && !buffer_source_select_i && !buffer_enable_i;
        state_next.buf_on = buffer_enable_i;
        state_next.feed = buffer_source_select_i;
        ref_active = pin_output_enable_i || buffer_enable_i;
        state_next.dout = ref_active ? 1'b0 : port_out_i;
        state_next.doe = ref_active ? 1'b0 : port_oe_i;
        if (ref_active) begin
            state_next.rd = 1'b0;
        end else if (state_reg.s2 == state_reg.s3) begin
            state_next.rd = state_reg.s3;
        end
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign unbuffered_ref_o     = state_reg.unbuf;
    assign buffered_ref_o       = state_reg.buf_on;
    assign buffer_feed_ladder_o = state_reg.feed;
    assign pin_dig_out_o        = state_reg.dout;
    assign pin_dig_oe_o         = state_reg.doe;
    assign pin_read_o           = state_reg.rd;
endmodule

// ---- logic/ref_ladder_control.sv ----
// Reference ladder control: Wishbone register file, ladder selects and pin routing.
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
module ref_ladder_control (
    input  wire logic                          sys_clk_i,
    input  wire logic                          arst_n_i,
    input  wire logic                          wb_cyc_i,
    input  wire logic                          wb_stb_i,
    input  wire logic                          wb_we_i,
    input  wire logic [ref_ladder_pkg::ADDR_W-1:0] wb_adr_i,
    input  wire logic [3:0]                    wb_sel_i,
    input  wire logic [31:0]                   wb_dat_i,
    input  wire logic                          sleep_i,
    input  wire logic                          port_out_i,
    input  wire logic                          port_oe_i,
    input  wire logic                          pin_in_i,
    output logic [31:0]                        wb_dat_o,
    output logic                               wb_ack_o,
    output logic                               ladder_power_o,
    output logic                               ladder_connect_o,
    output logic                               source_external_o,
    output logic [3:0]                         divisor_exp_o,
    output logic [ref_ladder_pkg::LEVEL_W-1:0] level_tap_o,
    output logic                               fixed_ref_enable_o,
    output logic                               unbuffered_ref_o,
    output logic                               buffered_ref_o,
    output logic                               buffer_feed_ladder_o,
    output logic                               pin_dig_out_o,
    output logic                               pin_dig_oe_o,
    output logic                               pin_read_o
);
    typedef struct packed {
        logic [7:0]                         ctrl_a;
        logic [ref_ladder_pkg::LEVEL_W-1:0] level;
        logic [7:0]                         fixed;
        logic                               ack;
        logic [31:0]                        rdata;
        logic                               power;
        logic                               connect;
        logic                               src_ext;
        logic [3:0]                         exp;
        logic [ref_ladder_pkg::LEVEL_W-1:0] tap;
        logic                               fixed_en;
    } ctl_s;

    ctl_s state_reg;
    ctl_s state_next;
    logic access;
    logic mux_pin_read;

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] read_word(input ctl_s s, input logic [ref_ladder_pkg::ADDR_W-1:0] a,
                                              input logic rd_pin);
        logic [31:0] w;
        w = ref_ladder_pkg::READ_ZERO;
        unique case (a)
            ref_ladder_pkg::ADDR_CONTROL_A:  w[7:0] = s.ctrl_a & ref_ladder_pkg::CTRL_A_MASK;
            ref_ladder_pkg::ADDR_LEVEL:      w[ref_ladder_pkg::LEVEL_W-1:0] = s.level;
            ref_ladder_pkg::ADDR_FIXED_REF:  w[7:0] = s.fixed & ref_ladder_pkg::FIXED_MASK;
            ref_ladder_pkg::ADDR_PIN_STATUS: w[0] = rd_pin;
            default:                         w = ref_ladder_pkg::READ_ZERO;
        endcase
        return w;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        state_next = state_reg;
        access = wb_cyc_i && wb_stb_i && !state_reg.ack;
        state_next.ack = access;
        state_next.rdata = access ? read_word(state_reg, wb_adr_i, mux_pin_read) : state_reg.rdata;
        // Sleep has no path into the registers, so a wake-up finds them as they were.
        // Powering down before sleep is left to software on purpose.
        if (access && wb_we_i && wb_sel_i[0]) begin
            unique case (wb_adr_i)
                ref_ladder_pkg::ADDR_CONTROL_A: state_next.ctrl_a = wb_dat_i[7:0] & ref_ladder_pkg::CTRL_A_MASK;
                ref_ladder_pkg::ADDR_LEVEL:     state_next.level = wb_dat_i[ref_ladder_pkg::LEVEL_W-1:0];
                ref_ladder_pkg::ADDR_FIXED_REF: state_next.fixed = wb_dat_i[7:0] & ref_ladder_pkg::FIXED_MASK;
                default: ;
            endcase
        end
        // Outputs follow the registers one edge later, with no handshake.
        state_next.power = state_reg.ctrl_a[ref_ladder_pkg::BIT_CONV_EN];
        state_next.connect = state_reg.ctrl_a[ref_ladder_pkg::BIT_CONV_EN];
        state_next.src_ext = state_reg.ctrl_a[ref_ladder_pkg::BIT_POS_SRC];
        state_next.exp = state_reg.ctrl_a[ref_ladder_pkg::BIT_RANGE_SEL] ? ref_ladder_pkg::EXP_FULL
                                                                         : ref_ladder_pkg::EXP_LIMITED;
        // A disabled ladder presents tap zero, which is zero volts in both ranges.
        state_next.tap = state_reg.ctrl_a[ref_ladder_pkg::BIT_CONV_EN] ? state_reg.level : '0;
        state_next.fixed_en = state_reg.fixed[ref_ladder_pkg::BIT_FIXED_EN];
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    ref_pin_mux pin_mux (
        .sys_clk_i              (sys_clk_i),
        .arst_n_i               (arst_n_i),
        .pin_output_enable_i    (state_reg.ctrl_a[ref_ladder_pkg::BIT_PIN_OE]),
        .buffer_enable_i        (state_reg.fixed[ref_ladder_pkg::BIT_BUF_EN]),
        .buffer_source_select_i (state_reg.fixed[ref_ladder_pkg::BIT_BUF_SRC]),
        .port_out_i             (port_out_i),
        .port_oe_i              (port_oe_i),
        .pin_in_i               (pin_in_i),
        .unbuffered_ref_o       (unbuffered_ref_o),
        .buffered_ref_o         (buffered_ref_o),
        .buffer_feed_ladder_o   (buffer_feed_ladder_o),
        .pin_dig_out_o          (pin_dig_out_o),
        .pin_dig_oe_o           (pin_dig_oe_o),
        .pin_read_o             (mux_pin_read)
    );

    assign pin_read_o         = mux_pin_read;
    assign wb_dat_o           = state_reg.rdata;
    assign wb_ack_o           = state_reg.ack;
    assign ladder_power_o     = state_reg.power;
    assign ladder_connect_o   = state_reg.connect;
    assign source_external_o  = state_reg.src_ext;
    assign divisor_exp_o      = state_reg.exp;
    assign level_tap_o        = state_reg.tap;
    assign fixed_ref_enable_o = state_reg.fixed_en;
endmodule

// ---- test/ladder_model.sv ----
// Behavioural model of the resistor ladder output, in units of the source over 512.
`timescale 1ns/10ps
module ladder_model (
    input  wire logic       power_i,
    input  wire logic [3:0] exp_i,
    input  wire logic [4:0] tap_i,
    output int              vout_o
);
    // A ladder that is switched off gives zero; each tap is worth 2 to the (9 - n) units.
    always_comb begin
        vout_o = (power_i && exp_i <= 4'h9) ? int'(tap_i) << (9 - int'(exp_i)) : 0;
    end
endmodule

// ---- test/ref_ladder_control_checker.sv ----
// Port assertions of the reference ladder control.
`timescale 1ns/10ps
module ref_ladder_control_checker (
    input wire logic        sys_clk_i,
    input wire logic        arst_n_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [3:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        ladder_power_o,
    input wire logic        ladder_connect_o,
    input wire logic [3:0]  divisor_exp_o,
    input wire logic [4:0]  level_tap_o,
    input wire logic        unbuffered_ref_o,
    input wire logic        buffered_ref_o,
    input wire logic        pin_dig_oe_o,
    input wire logic        pin_read_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!arst_n_i);
    sequence s_take; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
    sequence s_wr_ctrl; s_take ##0 (wb_we_i && wb_sel_i[0] && wb_adr_i == 4'h0); endsequence
    sequence s_rd_ctrl; s_take ##0 (!wb_we_i && wb_adr_i == 4'h0); endsequence
    ////////////////////////////////////////////////////////////////////////////////
    a_ack_after_take: assert property (s_take |=> wb_ack_o) else $error("ack missing");
    a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    a_enable_reaches: assert property (s_wr_ctrl |-> ##2 ladder_power_o == $past(wb_dat_i[7], 2))
        else $error("enable not applied");
    a_power_connect: assert property (ladder_power_o == ladder_connect_o) else $error("power mismatch");
    a_tap_when_off: assert property (!ladder_power_o |-> level_tap_o == 5'h00) else $error("tap live");
    a_exp_legal: assert property ($past(arst_n_i) |-> divisor_exp_o inside {4'h9, 4'h5})
        else $error("bad exponent");
    a_unbuf_alone: assert property (unbuffered_ref_o |-> !buffered_ref_o) else $error("both routes");
    a_pin_override: assert property ((unbuffered_ref_o || buffered_ref_o) |-> !pin_dig_oe_o && !pin_read_o)
        else $error("pin not overridden");
    a_read_masked: assert property (s_rd_ctrl |=> (wb_dat_o & 32'hffff_ff1b) == 32'h0)
        else $error("unused bits set");
endmodule
bind ref_ladder_control ref_ladder_control_checker i_chk (.*);

// ---- test/ref_ladder_control_tb_top.sv ----
// Self-checking testbench of the reference ladder control.
`timescale 1ns/10ps
module ref_ladder_control_tb_top;
    logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic slp = 1'b0, pout = 1'b0, poe = 1'b0, pin = 1'b0, ack, pwr, con, sx, fen, ub, bf, fl, dout, doe, prd;
    logic [3:0]  adr = 4'h0, sel = 4'h0, ex;
    logic [4:0]  tap;
    logic [31:0] dat = 32'h0, q, r, dat_o, rng = 32'h6dc7;
    int          vout, ca, lv, fx, err_total, total_checks;
    always #2.5 clk = ~clk;
    ref_ladder_control i_ref_ladder_control (.sys_clk_i(clk), .arst_n_i(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .sleep_i(slp), .port_out_i(pout),
        .port_oe_i(poe), .pin_in_i(pin), .wb_dat_o(dat_o), .wb_ack_o(ack), .ladder_power_o(pwr),
        .ladder_connect_o(con), .source_external_o(sx), .divisor_exp_o(ex), .level_tap_o(tap),
        .fixed_ref_enable_o(fen), .unbuffered_ref_o(ub), .buffered_ref_o(bf), .buffer_feed_ladder_o(fl),
        .pin_dig_out_o(dout), .pin_dig_oe_o(doe), .pin_read_o(prd));
    ladder_model i_ladder_model (.power_i(pwr), .exp_i(ex), .tap_i(tap), .vout_o(vout));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // The master never assumes a latency; a wait ends on ack or at the bound below.
    task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d, input logic [3:0] s,
                      output logic [31:0] rd);
        int n = 0;
        @(posedge clk);
        {cyc, stb, we, adr, sel, dat} <= {2'b11, w, a, s, 24'h0, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1) begin
            err_total++;
            results();
        end
        rd = dat_o;
        {cyc, stb} <= 2'b00;
    endtask
    task automatic check_all();
        logic ov;
        ov = ca[5] | fx[5];
        repeat (6) @(posedge clk);
        chk({pwr, con}, {ca[7], ca[7]});
        chk(sx, ca[2]);
        chk(ex, ca[6] ? 5 : 9);
        chk(vout, ca[7] ? lv * (ca[6] ? 16 : 1) : 0);
        chk(ub, ca[5] & ~fx[4] & ~fx[5]);
        chk({fen, bf, fl}, {fx[7], fx[5], fx[4]});
        chk({doe, dout, prd}, ov ? 0 : {poe, pout, pin});
        wb(1'b0, 4'h0, 8'h00, 4'hf, q);
        chk(q, ca);
        wb(1'b0, 4'h4, 8'h00, 4'hf, q);
        chk(q, lv);
        wb(1'b0, 4'h8, 8'h00, 4'hf, q);
        chk(q, fx);
        wb(1'b0, 4'hc, 8'h00, 4'hf, q);
        chk(q, ov ? 0 : pin);
        wb(1'b0, 4'h2, 8'h00, 4'hf, q);
        chk(q, 0);
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        check_all();
        for (int i = 0; i < 24; i++) begin
            r = xs();
            {slp, poe, pout, pin} <= r[3:0];
            wb(1'b1, 4'h0, r[15:8], r[19:16], q);
            if (r[16]) ca = r[15:8] & 8'he4;
            wb(1'b1, 4'h4, r[23:16], 4'h1, q);
            lv = r[20:16];
            wb(1'b1, 4'h8, r[31:24], 4'h1, q);
            fx = r[31:24] & 8'hb0;
            wb(1'b1, 4'h6, 8'hff, 4'hf, q);
            if (i == 12) begin
                rst_n <= 1'b0;
                repeat (2) @(posedge clk);
                rst_n <= 1'b1;
                ca = 0;
                lv = 0;
                fx = 0;
            end
            check_all();
        end
        results();
    end
endmodule
